// ### bench/smsp_core_asserts.sv
// checker for the serial port's register and pin outputs
`timescale 1ns/1ps
`default_nettype none
module smsp_core_asserts (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    input wire logic irq_o,
    input wire logic prog_active_i,
    input wire logic [3:0] pri_oe_o,
    input wire logic [3:0] alt_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rdz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("rdata not idle");
    property p_gie; irq_o |-> global_irq_en_i; endproperty
    a_gie: assert property (p_gie) else $error("irq ungated");
    property p_prg; prog_active_i && $past(prog_active_i) |-> !pri_oe_o; endproperty
    a_prg: assert property (p_prg) else $error("primary set live");
    property p_one; pri_oe_o != 4'h0 |-> alt_oe_o == 4'h0; endproperty
    a_one: assert property (p_one) else $error("both pin sets");
    property p_slv; pri_oe_o[1] |-> pri_oe_o[3:2] == 2'h0 && !pri_oe_o[0]; endproperty
    a_slv: assert property (p_slv) else $error("slave drives input");
    property p_mst; pri_oe_o[2] || alt_oe_o[2] |-> !pri_oe_o[1] && !alt_oe_o[1];
    endproperty
    a_mst: assert property (p_mst) else $error("master drives miso");
    property p_fal; $fell(irq_o) |-> $past(irq_ack_i) || $past(rd_i) ||
        $past(wr_i) || !global_irq_en_i; endproperty
    a_fal: assert property (p_fal) else $error("irq dropped");
    property p_rst; $rose(nrst_i) |-> !pri_oe_o && !alt_oe_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("not quiet");
endmodule
bind smsp_core smsp_core_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i),
    .prog_active_i(prog_active_i), .pri_oe_o(pri_oe_o), .alt_oe_o(alt_oe_o));
`default_nettype wire

// ### bench/smsp_partner.sv
// far-side model: mode 0 slave, or master on request
`timescale 1ns/1ps
`default_nettype none
module smsp_partner (
    input wire logic clk_i,
    input wire logic [3:0] pin_i,
    output logic [3:0] drv_o,
    output logic [3:0] en_o
);
    logic m_en = 1'h0;
    logic ss_v = 1'h1;
    logic sck_v = 1'h0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rx_b = 8'h00;
    assign en_o = {m_en, m_en, !m_en && !pin_i[3], m_en};
    assign drv_o = {ss_v, sck_v, sh[7], sh[7]};
    always @(posedge pin_i[2])
        if (!pin_i[3])
            rx_b = {rx_b[6:0], pin_i[m_en ? 1 : 0]};
    always @(negedge pin_i[2])
        if (!pin_i[3])
            sh = sh << 1;
    task automatic xfer(input logic [7:0] b);
        @(negedge clk_i);
        sh = b;
        m_en = 1'h1;
        ss_v = 1'h0;
        repeat (4) @(negedge clk_i);
        repeat (8) begin
            repeat (4) @(negedge clk_i);
            sck_v = 1'h1;
            repeat (4) @(negedge clk_i);
            sck_v = 1'h0;
        end
        repeat (4) @(negedge clk_i);
        ss_v = 1'h1;
        m_en = 1'h0;
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the serial master/slave port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smsp_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, rd_d = 1'h0;
    logic gie = 1'h1, ack = 1'h0, prog = 1'h0, tgl = 1'h0, irq;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, d, s;
    logic [3:0] pin, p_drv, p_en, pri_out, pri_oe, alt_out, alt_oe;
    logic [3:0] alt_in = 4'hF;
    logic [7:0] exp_q[$];
    int error_cnt = 0, checked = 0, n;
    int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    smsp_core dut (.clk_i(clk), .nrst_i(nrst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq),
        .prog_active_i(prog), .pri_in_i(pin), .pri_out_o(pri_out),
        .pri_oe_o(pri_oe), .alt_in_i(alt_in), .alt_out_o(alt_out),
        .alt_oe_o(alt_oe));
    smsp_partner p (.clk_i(clk), .pin_i(pin), .drv_o(p_drv), .en_o(p_en));
    initial forever #10 clk = ~clk;
    always @(posedge clk) tgl <= ~tgl;
    always @(posedge clk) rd_d <= rd;
    always_comb
        for (int k = 0; k < 4; k++)
            pin[k] = pri_oe[k] ? pri_out[k] : p_en[k] ? p_drv[k] :
                k == 3 ? 1'h1 : k == 2 ? 1'h0 : tgl;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    always @(negedge clk)
        if (rd_d) chk("rdata", rdata, exp_q.pop_front());
    task automatic w(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic r(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
    endtask
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'h1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        d = 8'($urandom(32'h2F68));
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        r(SMSP_ADDR_CTRL, SMSP_CTRL_RST);
        r(SMSP_ADDR_STAT, 8'h00);
        r(3'h7, 8'h00);
        w(SMSP_ADDR_MCU, 8'hFF);
        r(SMSP_ADDR_MCU, SMSP_MCU_MASK);
        w(SMSP_ADDR_MCU, SMSP_MCU_RST);
        w(SMSP_ADDR_DIR, 8'h0D);
        $display("registers done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            s = 8'($urandom);
            p.sh = s;
            w(SMSP_ADDR_STAT, {7'h00, i > 3});
            w(SMSP_ADDR_CTRL, 8'hD0 | 8'(i % 4));
            w(SMSP_ADDR_DATA, d);
            if (i == 0)
                w(SMSP_ADDR_DATA, ~d);
            wait_irq;
            n = n - 8 * dv[i];
            chk("sck rate", 8'(n > -13 && n < 9), 8'h01);
            chk("mosi", p.rx_b, d);
            r(SMSP_ADDR_STAT, {1'h1, i == 0, 5'h00, i > 3});
            r(SMSP_ADDR_DATA, s);
            @(negedge clk);
            chk("irq", {7'h00, irq}, 8'h00);
        end
        $display("master done");
        w(SMSP_ADDR_STAT, 8'h00);
        w(SMSP_ADDR_DIR, 8'h05);
        @(negedge clk);
        p.m_en = 1'h1;
        p.ss_v = 1'h0;
        repeat (6) @(posedge clk);
        r(SMSP_ADDR_CTRL, 8'hC3);
        chk("fault irq", {7'h00, irq}, 8'h01);
        ack <= 1'h1;
        @(posedge clk);
        ack <= 1'h0;
        @(negedge clk);
        chk("ack irq", {7'h00, irq}, 8'h00);
        p.m_en = 1'h0;
        p.ss_v = 1'h1;
        $display("fault done");
        w(SMSP_ADDR_CTRL, 8'hC0);
        w(SMSP_ADDR_DIR, 8'h02);
        w(SMSP_ADDR_DATA, d);
        chk("idle miso", {7'h00, pri_oe[1]}, 8'h00);
        p.xfer(s);
        wait_irq;
        chk("miso", p.rx_b, d);
        r(SMSP_ADDR_STAT, 8'h80);
        r(SMSP_ADDR_DATA, s);
        $display("slave done");
        w(SMSP_ADDR_CTRL, 8'hD0);
        w(SMSP_ADDR_DIR, 8'h1D);
        @(negedge clk);
        chk("pri oe", {pri_oe, alt_oe}, 8'hD0);
        w(SMSP_ADDR_MCU, 8'h80);
        repeat (3) @(negedge clk);
        chk("alt oe", {pri_oe, alt_oe}, 8'h0D);
        w(SMSP_ADDR_MCU, SMSP_MCU_RST);
        prog <= 1'h1;
        repeat (3) @(negedge clk);
        chk("prog oe", {pri_oe, alt_oe}, 8'h0D);
        $display("redirect done");
        print_verdict;
    end
endmodule
`default_nettype wire

// ### src/smsp_core.sv
// serial master/slave port with register port and pin redirect
// Behaviour
// - master data write starts eight-bit exchange
// - master stops clock, sets done after byte
// - done with enable requests interrupt
// - last received byte kept in buffer
// - slave idle, miso off while select high
// - slave shifts only after select low
// - transmit path has single buffer
// - receive double buffered, unread byte lost
// - enabled port forces pin directions
// - slave select input, low enables miso
// - select high resets slave shift logic
// - master output select is plain gpio
// - master select input low forces slave
// - mode fault sets done, may interrupt
// - mosi master to slave, miso back
// - redirect bit picks alternate pin set
// - programming port stays on alternate pins
// - rate bits and doubler divide clock
// - data write during transfer sets collision
// - done cleared by vector or read-access
// - polarity and phase select four modes
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smsp_core
    import smsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    input wire logic prog_active_i,
    input wire logic [3:0] pri_in_i,
    output logic [3:0] pri_out_o,
    output logic [3:0] pri_oe_o,
    input wire logic [3:0] alt_in_i,
    output logic [3:0] alt_out_o,
    output logic [3:0] alt_oe_o
);
    // pin vector order: 0 mosi, 1 miso, 2 sck, 3 ss
    logic [7:0] ctrl_r, mcu_r, dir_r, shift_r, rxbuf_r, rdata_r;
    logic done_r, write_collision_flag_r, dbl_r, stat_seen_r;
    logic [3:0] in_s1_r, in_s2_r;
    logic sck_prev_r, ss_prev_r;
    logic [6:0] div_r;
    logic [3:0] edge_r;
    logic busy_r, sck_r;
    logic miso_r, mosi_r, in_bit_r;
    logic [1:0] samp_d_r, fin_d_r;
    logic [7:0] mrx_r, mrx_nxt;

    logic en, master, alt, cpol, cpha, lsb;
    logic [3:0] pin_in;
    logic ss_in, sck_in, mosi_in, miso_in;
    logic fault, slave_act, s_edge, s_lead, s_trail;
    logic m_tick, m_lead, m_last;
    logic data_wr, data_rd, done_set, byte_end;
    logic [6:0] div_top;
    logic out_bit;
    logic [7:0] rx_nxt;

    assign en = ctrl_r[SMSP_CTRL_PORT_EN];
    assign master = ctrl_r[SMSP_CTRL_ROLE];
    assign cpol = ctrl_r[SMSP_CTRL_CPOL];
    assign cpha = ctrl_r[SMSP_CTRL_CPHA];
    assign lsb = ctrl_r[SMSP_CTRL_ORDER];
    // programming access pins the port to the alternate set
    assign alt = mcu_r[SMSP_MCU_REDIRECT] | prog_active_i;

    // two-flop synchroniser on whichever pin set alt selects
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_s1_r <= 4'hF;
            in_s2_r <= 4'hF;
        end else begin
            in_s1_r <= alt ? alt_in_i : pri_in_i;
            in_s2_r <= in_s1_r;
        end
    end
    assign pin_in = in_s2_r;
    assign mosi_in = pin_in[0];
    assign miso_in = pin_in[1];
    assign sck_in = pin_in[2];
    assign ss_in = pin_in[3];

    assign fault = en && master && !dir_r[SMSP_DIR_SS] && !ss_in;
    assign slave_act = en && !master && !ss_in;
    // sampled sck edges; external clock must be slow enough
    assign s_edge = slave_act && !ss_prev_r && (sck_in != sck_prev_r);
    assign s_lead = s_edge && (sck_in != cpol);
    assign s_trail = s_edge && (sck_in == cpol);

    always_comb begin
        case ({dbl_r, ctrl_r[1:0]})
            3'h0: div_top = 7'h01;
            3'h1: div_top = 7'h07;
            3'h2: div_top = 7'h1F;
            3'h3: div_top = 7'h3F;
            3'h4: div_top = 7'h00;
            3'h5: div_top = 7'h03;
            3'h6: div_top = 7'h0F;
            default: div_top = 7'h1F;
        endcase
    end
    assign m_tick = busy_r && master && (div_r == div_top);
    assign m_lead = !edge_r[0];
    assign m_last = m_tick && (edge_r == SMSP_EDGES);

    assign data_wr = wr_i && addr_i == SMSP_ADDR_DATA;
    assign data_rd = rd_i && addr_i == SMSP_ADDR_DATA;
    // master samples miso two clocks late to cover the synchroniser
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            samp_d_r <= 2'h0;
            fin_d_r <= 2'h0;
            mrx_r <= 8'h00;
        end else if (!en || fault) begin
            samp_d_r <= 2'h0;
            fin_d_r <= 2'h0;
        end else begin
            samp_d_r <= {samp_d_r[0], m_tick && (m_lead == !cpha)};
            fin_d_r <= {fin_d_r[0], m_last};
            if (samp_d_r[1])
                mrx_r <= mrx_nxt;
        end
    end
    assign mrx_nxt = lsb ? {miso_in, mrx_r[7:1]} : {mrx_r[6:0], miso_in};

    assign byte_end = fin_d_r[1] || (slave_act && busy_r && s_trail
        && edge_r == SMSP_EDGES);
    assign done_set = (en && byte_end) || fault;
    assign out_bit = lsb ? shift_r[0] : shift_r[7];
    assign rx_nxt = lsb ? {in_bit_r, shift_r[7:1]} : {shift_r[6:0], in_bit_r};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else begin
            sck_prev_r <= sck_in;
            ss_prev_r <= ss_in;
        end
    end

    // control registers; fault clears role bit
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= SMSP_CTRL_RST;
            mcu_r <= SMSP_MCU_RST;
            dir_r <= 8'h00;
            dbl_r <= 1'b0;
        end else begin
            if (wr_i && addr_i == SMSP_ADDR_CTRL)
                ctrl_r <= wdata_i;
            if (wr_i && addr_i == SMSP_ADDR_MCU)
                mcu_r <= wdata_i & SMSP_MCU_MASK;
            if (wr_i && addr_i == SMSP_ADDR_DIR)
                dir_r <= {3'h0, wdata_i[4:0]};
            if (wr_i && addr_i == SMSP_ADDR_STAT)
                dbl_r <= wdata_i[SMSP_STAT_DOUBLE];
            if (fault)
                ctrl_r[SMSP_CTRL_ROLE] <= 1'b0;
        end
    end

    // status flags, set wins over clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            stat_seen_r <= 1'b0;
        end else begin
            if (rd_i && addr_i == SMSP_ADDR_STAT)
                stat_seen_r <= done_r | write_collision_flag_r;
            else if (data_wr || data_rd)
                stat_seen_r <= 1'b0;
            if (done_set)
                done_r <= 1'b1;
            else if (irq_ack_i || (stat_seen_r && (data_wr || data_rd)))
                done_r <= 1'b0;
            if (data_wr && (busy_r || fin_d_r != 2'h0) && en)
                write_collision_flag_r <= 1'b1;
            else if (stat_seen_r && (data_wr || data_rd))
                write_collision_flag_r <= 1'b0;
        end
    end
    assign irq_o = done_r && ctrl_r[SMSP_CTRL_IRQ_EN]
        && global_irq_en_i;

    // shift engine for both roles
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_r <= 8'h00;
            rxbuf_r <= 8'h00;
            busy_r <= 1'b0;
            edge_r <= 4'h0;
            div_r <= 7'h00;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            miso_r <= 1'b0;
            in_bit_r <= 1'b0;
        end else if (!en || fault) begin
            busy_r <= 1'b0;
            edge_r <= 4'h0;
            div_r <= 7'h00;
            sck_r <= cpol;
        end else if (master) begin
            if (fin_d_r[1])
                rxbuf_r <= samp_d_r[1] ? mrx_nxt : mrx_r;
            if (data_wr && !busy_r && fin_d_r == 2'h0) begin
                shift_r <= wdata_i;
                busy_r <= 1'b1;
                edge_r <= 4'h0;
                div_r <= 7'h00;
                if (!cpha)
                    mosi_r <= lsb ? wdata_i[0] : wdata_i[7];
            end else if (busy_r) begin
                div_r <= m_tick ? 7'h00 : 7'(div_r + 7'h01);
                if (m_tick) begin
                    sck_r <= ~sck_r;
                    edge_r <= 4'(edge_r + 4'h1);
                    if (m_lead == !cpha)
                        in_bit_r <= miso_in;
                    else begin
                        shift_r <= rx_nxt;
                        mosi_r <= lsb ? rx_nxt[0] : rx_nxt[7];
                    end
                    if (cpha && m_lead)
                        mosi_r <= out_bit;
                    if (m_last) begin
                        busy_r <= 1'b0;
                    end
                end
            end else
                sck_r <= cpol;
        end else if (ss_in) begin
            busy_r <= 1'b0;
            edge_r <= 4'h0;
            if (data_wr)
                shift_r <= wdata_i;
        end else begin
            if (data_wr && !busy_r)
                shift_r <= wdata_i;
            if (!busy_r)
                miso_r <= out_bit;
            if (s_edge) begin
                busy_r <= 1'b1;
                edge_r <= 4'(edge_r + 4'h1);
                if (s_lead == !cpha)
                    in_bit_r <= mosi_in;
                else begin
                    shift_r <= rx_nxt;
                    miso_r <= lsb ? rx_nxt[0] : rx_nxt[7];
                end
                if (cpha && s_lead)
                    miso_r <= out_bit;
                if (edge_r == SMSP_EDGES) begin
                    busy_r <= 1'b0;
                    edge_r <= 4'h0;
                    rxbuf_r <= rx_nxt;
                end
            end
        end
    end

    // pin drive: direction forced by role
    logic [3:0] pout, poe;
    always_comb begin
        pout = {dir_r[SMSP_DIR_SS_LVL], sck_r, miso_r, mosi_r};
        poe = 4'h0;
        if (en && master) begin
            poe[0] = dir_r[SMSP_DIR_MOSI];
            poe[2] = dir_r[SMSP_DIR_SCK];
            poe[3] = dir_r[SMSP_DIR_SS];
        end else if (en) begin
            poe[1] = dir_r[SMSP_DIR_MISO] && !ss_in;
        end
    end
    assign pri_out_o = pout;
    assign alt_out_o = pout;
    assign pri_oe_o = alt ? 4'h0 : poe;
    assign alt_oe_o = alt ? poe : 4'h0;

    // read port, data one cycle after strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            rdata_r <= 8'h00;
        else if (rd_i) begin
            case (addr_i)
                SMSP_ADDR_CTRL: rdata_r <= ctrl_r;
                SMSP_ADDR_STAT: rdata_r <= {done_r, write_collision_flag_r, 5'h00, dbl_r};
                SMSP_ADDR_DATA: rdata_r <= rxbuf_r;
                SMSP_ADDR_MCU: rdata_r <= mcu_r;
                SMSP_ADDR_DIR: rdata_r <= dir_r;
                default: rdata_r <= 8'h00;
            endcase
        end else
            rdata_r <= 8'h00;
    end
    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// ### src/smsp_pkg.sv
// constants for the serial master/slave port
package smsp_pkg;
    localparam logic [2:0] SMSP_ADDR_CTRL = 3'h0;
    localparam logic [2:0] SMSP_ADDR_STAT = 3'h1;
    localparam logic [2:0] SMSP_ADDR_DATA = 3'h2;
    localparam logic [2:0] SMSP_ADDR_MCU = 3'h3;
    localparam logic [2:0] SMSP_ADDR_DIR = 3'h4;
    localparam int SMSP_CTRL_IRQ_EN = 7;
    localparam int SMSP_CTRL_PORT_EN = 6;
    localparam int SMSP_CTRL_ORDER = 5;
    localparam int SMSP_CTRL_ROLE = 4;
    localparam int SMSP_CTRL_CPOL = 3;
    localparam int SMSP_CTRL_CPHA = 2;
    localparam int SMSP_STAT_DONE = 7;
    localparam int SMSP_STAT_WRITE_COLLISION_FLAG = 6;
    localparam int SMSP_STAT_DOUBLE = 0;
    localparam int SMSP_MCU_REDIRECT = 7;
    localparam int SMSP_DIR_MOSI = 0;
    localparam int SMSP_DIR_MISO = 1;
    localparam int SMSP_DIR_SCK = 2;
    localparam int SMSP_DIR_SS = 3;
    localparam int SMSP_DIR_SS_LVL = 4;
    localparam logic [7:0] SMSP_CTRL_RST = 8'h00;
    localparam logic [7:0] SMSP_MCU_RST = 8'h00;
    localparam logic [7:0] SMSP_MCU_MASK = 8'h80;
    localparam int SMSP_BITS = 8;
    localparam logic [3:0] SMSP_EDGES = 4'hF;
    localparam int SMSP_CLK_MHZ = 50;
endpackage
